//--- verilog/xdm_pkg.sv
// xdm_pkg: constants shared by the external data move block.
// assumes: special-function addresses are 8 bits, data bytes are 8 bits.
package xdm_pkg;

  // special-function register addresses
  localparam logic [7:0] ADDR_POINTER0_LOW  = 8'h82;
  localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_POINTER1_LOW  = 8'h84;
  localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SEL   = 8'h86;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;

  // reset values
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h01;
  localparam logic [7:0] RST_POINTER_SEL   = 8'h00;
  localparam logic [7:0] RST_POINTER_BYTE  = 8'h00;

  // field layout
  localparam int STRETCH_LSB   = 0;
  localparam int STRETCH_W     = 3;
  localparam int SEL_BIT       = 0;
  localparam logic [7:0] SEL_MASK = 8'h01;

  // timing, in clocks
  localparam int MC_CLOCKS        = 4;
  localparam int ALE_CLOCKS       = 2;
  localparam int SHORT_STROBE     = 2;
  localparam int SHORT_TAIL       = 2;
  localparam int LONG_TAIL        = 4;
  localparam int CNT_W            = 5;

  // sequencer states
  typedef enum logic [3:0] {
    XDM_IDLE   = 4'b0001,
    XDM_ADDR   = 4'b0010,
    XDM_STROBE = 4'b0100,
    XDM_TAIL   = 4'b1000
  } xdm_state_t;

endpackage

//--- verilog/xdm_seq_if.sv
// xdm_seq_if: carries start, stretch and phase flags between control and sequencer.
// assumes: both ends share clk.
`timescale 1ns/1ns
`default_nettype none
interface xdm_seq_if;
  logic       start;
  logic [2:0] stretch;
  logic       busy;
  logic       ale_phase;
  logic       addr_phase;
  logic       strobe_phase;
  logic       last;

  modport seq (input start, stretch, output busy, ale_phase, addr_phase, strobe_phase, last);
  modport ctl (output start, stretch, input busy, ale_phase, addr_phase, strobe_phase, last);
endinterface
`default_nettype wire

//--- verilog/xdm_seq.sv
// xdm_seq: machine-cycle sequencer for one external data move.
// assumes: start is only honoured while idle; stretch is sampled at start.
`timescale 1ns/1ns
`default_nettype none
module xdm_seq (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control side
  xdm_seq_if.seq    sq
);

  // strobe width: two clocks at zero, four per stretch step otherwise
  function automatic logic [xdm_pkg::CNT_W-1:0] strobe_len(input logic [2:0] s);
    if (s == 3'h0) begin
      strobe_len = xdm_pkg::CNT_W'(xdm_pkg::SHORT_STROBE); // [RL2]
    end else begin
      strobe_len = xdm_pkg::CNT_W'(xdm_pkg::MC_CLOCKS * s); // [RL4] [RL9]
    end
  endfunction

  // tail pads the move out to (stretch + 2) machine cycles
  function automatic logic [xdm_pkg::CNT_W-1:0] tail_len(input logic [2:0] s);
    tail_len = (s == 3'h0) ? xdm_pkg::CNT_W'(xdm_pkg::SHORT_TAIL)
                           : xdm_pkg::CNT_W'(xdm_pkg::LONG_TAIL); // [RL3]
  endfunction

  xdm_pkg::xdm_state_t       state;
  xdm_pkg::xdm_state_t       next_state;
  logic [xdm_pkg::CNT_W-1:0] cnt;
  logic [xdm_pkg::CNT_W-1:0] next_cnt;
  logic [2:0]                stretch;
  logic [2:0]                next_stretch;
  logic                      cnt_done;

  assign cnt_done = (cnt == xdm_pkg::CNT_W'(1));

  // phase advance; each phase loads its own length
  always_comb begin
    next_state   = state;
    next_cnt     = cnt - xdm_pkg::CNT_W'(1);
    next_stretch = stretch;
    unique case (state)
      xdm_pkg::XDM_IDLE: begin
        next_cnt = cnt;
        if (sq.start) begin
          next_state   = xdm_pkg::XDM_ADDR;
          next_cnt     = xdm_pkg::CNT_W'(xdm_pkg::MC_CLOCKS); // [RL9]
          next_stretch = sq.stretch; // [RL7]
        end
      end
      xdm_pkg::XDM_ADDR: begin
        if (cnt_done) begin
          next_state = xdm_pkg::XDM_STROBE;
          next_cnt   = strobe_len(stretch);
        end
      end
      xdm_pkg::XDM_STROBE: begin
        if (cnt_done) begin
          next_state = xdm_pkg::XDM_TAIL;
          next_cnt   = tail_len(stretch);
        end
      end
      xdm_pkg::XDM_TAIL: begin
        if (cnt_done) begin
          next_state = xdm_pkg::XDM_IDLE;
        end
      end
      default: begin
        next_state = xdm_pkg::XDM_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= xdm_pkg::XDM_IDLE;
      cnt     <= '0;
      stretch <= '0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      stretch <= next_stretch;
    end
  end

  // phase flags toward the control side
  assign sq.busy         = (state != xdm_pkg::XDM_IDLE);
  assign sq.addr_phase   = (state == xdm_pkg::XDM_ADDR);
  assign sq.ale_phase    = sq.addr_phase && (cnt > xdm_pkg::CNT_W'(xdm_pkg::ALE_CLOCKS));
  assign sq.strobe_phase = (state == xdm_pkg::XDM_STROBE);
  assign sq.last         = (state == xdm_pkg::XDM_TAIL) && cnt_done;

endmodule
`default_nettype wire

//--- verilog/xdm_top.sv
// xdm_top: external data move timing, stretch control and dual data pointer.
// assumes: the core drives the special-function port and move requests on clk;
// only addr_data_in comes from outside and is synchronised here.
//
// Behaviour
// [RL1] clock control low three bits hold stretch 0..7 for data moves.
// [RL2] stretch zero: move takes two machine cycles, strobe two clocks.
// [RL3] move lasts stretch plus two machine cycles; seven gives nine.
// [RL4] nonzero stretch N widens the strobe to 4*N clocks.
// [RL5] reset loads stretch 1, three-cycle moves.
// [RL6] stretch affects only data moves, never program fetch timing.
// [RL7] stretch may change anytime; next moves use the new value.
// [RL8] clock control register sits at address 8Eh.
// [RL9] one machine cycle counts as four clocks.
// [RL10] two 16-bit pointers at 82h/83h and 84h/85h.
// [RL11] bit 0 of 86h selects pointer; other bits read zero.
// [RL12] pointer loads, increments and moves use the selected pointer.
// [RL13] incrementing 86h toggles its low bit.
// [RL14] reset clears the select bit, primary pointer active.
// [RL15] low address multiplexed with data; high byte on separate port.
// [RL16] memory answers or accepts data within the strobe width.
// [RL17] each move asserts only read or write strobe for whole width.
`timescale 1ns/1ns
`default_nettype none
module xdm_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // special-function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_inc,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // data pointer operations
  input  wire logic        data_pointer_load,
  input  wire logic [15:0] data_pointer_value,
  input  wire logic        data_pointer_inc,
  output logic      [15:0] data_pointer,
  // external data move requests
  input  wire logic        ext_data_move_start,
  input  wire logic        ext_data_move_write,
  input  wire logic        ext_data_move_use_ri,
  input  wire logic [7:0]  ext_data_move_ri_addr,
  input  wire logic [7:0]  ext_data_move_page,
  input  wire logic [7:0]  ext_data_move_wdata,
  output logic             ext_data_move_busy,
  output logic             ext_data_move_done,
  output logic      [7:0]  ext_data_move_rdata,
  // memory pins
  input  wire logic [7:0]  addr_data_in,
  output logic      [7:0]  addr_data_out,
  output logic             addr_data_oe,
  output logic      [7:0]  high_addr_port,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n
);

  // byte increment shared by the special-function increment path
  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  // select a byte from a 16-bit pointer
  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  xdm_seq_if sq ();

  // registers
  logic [7:0]  clock_control;
  logic [7:0]  pointer_select;
  logic [15:0] primary_pointer;
  logic [15:0] alternate_pointer;
  logic [7:0]  next_clock_control;
  logic [7:0]  next_pointer_select;
  logic [15:0] next_primary_pointer;
  logic [15:0] next_alternate_pointer;

  // move context captured at start
  logic [15:0] mv_addr;
  logic [7:0]  mv_wdata;
  logic        mv_write;
  logic [15:0] next_mv_addr;

  // synchroniser for the returning data byte
  logic [7:0]  adin_meta;
  logic [7:0]  adin_sync;
  logic [1:0]  rd_win;

  // decode
  wire         hit_p0l;
  wire         hit_p0h;
  wire         hit_p1l;
  wire         hit_p1h;
  wire         hit_sel;
  wire         hit_ckc;
  wire         hit_any;
  wire         pointer_select_bit;
  wire [2:0]   stretch;
  wire [15:0]  active_pointer;
  wire [7:0]  read_value;
  wire [7:0]  write_value;
  wire         sfr_change;
  wire         move_accept;
  wire         strobe_on;
  wire         drive_data;

  assign hit_p0l = (sfr_addr == xdm_pkg::ADDR_POINTER0_LOW);  // [RL10]
  assign hit_p0h = (sfr_addr == xdm_pkg::ADDR_POINTER0_HIGH); // [RL10]
  assign hit_p1l = (sfr_addr == xdm_pkg::ADDR_POINTER1_LOW);  // [RL10]
  assign hit_p1h = (sfr_addr == xdm_pkg::ADDR_POINTER1_HIGH); // [RL10]
  assign hit_sel = (sfr_addr == xdm_pkg::ADDR_POINTER_SEL);   // [RL11]
  assign hit_ckc = (sfr_addr == xdm_pkg::ADDR_CLOCK_CONTROL); // [RL8]
  assign hit_any = hit_p0l | hit_p0h | hit_p1l | hit_p1h | hit_sel | hit_ckc;

  // field views
  assign pointer_select_bit = pointer_select[xdm_pkg::SEL_BIT];
  assign stretch = clock_control[xdm_pkg::STRETCH_LSB +: xdm_pkg::STRETCH_W]; // [RL1]
  assign active_pointer = pointer_select_bit ? alternate_pointer
                                             : primary_pointer; // [RL12]

  // read multiplexer; unmapped addresses read zero
  assign read_value =
    hit_p0l ? byte_of(primary_pointer, 1'b0)   :
    hit_p0h ? byte_of(primary_pointer, 1'b1)   :
    hit_p1l ? byte_of(alternate_pointer, 1'b0) :
    hit_p1h ? byte_of(alternate_pointer, 1'b1) :
    hit_sel ? pointer_select                   :
    hit_ckc ? clock_control                    : 8'h00;

  // increment is a read-modify-write of the addressed byte
  assign sfr_change  = sfr_wr | sfr_inc;
  assign write_value = sfr_wr ? sfr_wdata : inc8(read_value);

  // clock control: all bits stored, low three steer the move length
  always_comb begin
    next_clock_control = clock_control;
    if (sfr_change && hit_ckc) begin
      next_clock_control = write_value; // [RL7] [RL8]
    end
  end

  // select register keeps only bit 0, so an increment toggles it
  always_comb begin
    next_pointer_select = pointer_select;
    if (sfr_change && hit_sel) begin
      next_pointer_select = write_value & xdm_pkg::SEL_MASK; // [RL11] [RL13]
    end
  end

  // primary pointer: core load or increment first, byte writes override
  always_comb begin
    next_primary_pointer = primary_pointer;
    if (!pointer_select_bit && data_pointer_load) begin
      next_primary_pointer = data_pointer_value; // [RL12]
    end else if (!pointer_select_bit && data_pointer_inc) begin
      next_primary_pointer = primary_pointer + 16'h0001; // [RL12]
    end
    if (sfr_change && hit_p0l) begin
      next_primary_pointer[7:0] = write_value; // [RL10]
    end
    if (sfr_change && hit_p0h) begin
      next_primary_pointer[15:8] = write_value; // [RL10]
    end
  end

  // alternate pointer, same structure
  always_comb begin
    next_alternate_pointer = alternate_pointer;
    if (pointer_select_bit && data_pointer_load) begin
      next_alternate_pointer = data_pointer_value; // [RL12]
    end else if (pointer_select_bit && data_pointer_inc) begin
      next_alternate_pointer = alternate_pointer + 16'h0001; // [RL12]
    end
    if (sfr_change && hit_p1l) begin
      next_alternate_pointer[7:0] = write_value; // [RL10]
    end
    if (sfr_change && hit_p1h) begin
      next_alternate_pointer[15:8] = write_value; // [RL10]
    end
  end

  // register state
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_control     <= xdm_pkg::RST_CLOCK_CONTROL; // [RL5]
      pointer_select    <= xdm_pkg::RST_POINTER_SEL;   // [RL14]
      primary_pointer   <= {2{xdm_pkg::RST_POINTER_BYTE}};
      alternate_pointer <= {2{xdm_pkg::RST_POINTER_BYTE}};
    end else begin
      clock_control     <= next_clock_control;
      pointer_select    <= next_pointer_select;
      primary_pointer   <= next_primary_pointer;
      alternate_pointer <= next_alternate_pointer;
    end
  end

  // registered read port, one clock behind the address
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_rdata <= read_value;
      sfr_hit   <= hit_any;
    end
  end

  // registered view of the active pointer for the core
  always_ff @(posedge clk) begin
    if (srst) begin
      data_pointer <= {2{xdm_pkg::RST_POINTER_BYTE}};
    end else begin
      data_pointer <= active_pointer; // [RL12]
    end
  end

  // start only while idle; a request during a move is dropped, so the
  // core must wait for done before asking again
  assign move_accept = ext_data_move_start && !sq.busy;
  assign sq.start    = move_accept;
  assign sq.stretch  = stretch; // [RL6] [RL7]

  // address: pointer moves use the selected pointer, register-indirect
  // moves put the page byte on the high port
  assign next_mv_addr = ext_data_move_use_ri ? {ext_data_move_page, ext_data_move_ri_addr}
                                             : active_pointer; // [RL12]

  // capture the move context
  always_ff @(posedge clk) begin
    if (srst) begin
      mv_addr  <= 16'h0000;
      mv_wdata <= 8'h00;
      mv_write <= 1'b0;
    end else if (move_accept) begin
      mv_addr  <= next_mv_addr;
      mv_wdata <= ext_data_move_wdata;
      mv_write <= ext_data_move_write;
    end
  end

  xdm_seq u_seq (
    .clk  (clk),
    .srst (srst),
    .sq   (sq.seq)
  );

  // pin drive decisions; pins lag the sequencer by one clock
  assign strobe_on  = sq.strobe_phase;
  assign drive_data = sq.addr_phase || (mv_write && sq.busy && !sq.addr_phase);

  // address latch enable and both strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      ale  <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else begin
      ale  <= sq.ale_phase;                 // [RL15]
      rd_n <= !(strobe_on && !mv_write);    // [RL17]
      wr_n <= !(strobe_on && mv_write);     // [RL17]
    end
  end

  // multiplexed low port: address first, then write data or released
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_data_out  <= 8'h00;
      addr_data_oe   <= 1'b0;
      high_addr_port <= 8'h00;
    end else begin
      addr_data_out  <= sq.addr_phase ? mv_addr[7:0] : mv_wdata; // [RL15]
      addr_data_oe   <= drive_data;
      high_addr_port <= sq.busy ? mv_addr[15:8] : high_addr_port; // [RL15]
    end
  end

  // two-flop synchroniser on the returning byte
  always_ff @(posedge clk) begin
    if (srst) begin
      adin_meta <= 8'h00;
      adin_sync <= 8'h00;
    end else begin
      adin_meta <= addr_data_in;
      adin_sync <= adin_meta;
    end
  end

  // read window delayed by the synchroniser depth, so every captured byte
  // was on the pins while rd_n was low; the last one is from the clock
  // before the strobe ends, which keeps a zero-stretch read inside the move
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_win <= 2'h0;
    end else begin
      rd_win <= {rd_win[0], strobe_on && !mv_write && !rd_n};
    end
  end

  // memory must settle one clock before the strobe ends
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_data_move_rdata <= 8'h00;
    end else if (rd_win[1]) begin
      ext_data_move_rdata <= adin_sync; // [RL16]
    end
  end

  // busy and one-clock done pulse at the end of the final machine cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_data_move_busy <= 1'b0;
      ext_data_move_done <= 1'b0;
    end else begin
      ext_data_move_busy <= sq.busy && !sq.last; // [RL3]
      ext_data_move_done <= sq.last;             // [RL2] [RL3]
    end
  end

endmodule
`default_nettype wire

//--- dv/xdm_props.sv
// xdm_props: pin timing and register port checks for the data move block.
// assumes: bound to xdm_top; clock control changes only by plain writes.
`timescale 1ns/1ns
`default_nettype none
module xdm_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  // move control
  input wire logic       ext_data_move_start,
  input wire logic       ext_data_move_write,
  input wire logic       ext_data_move_done,
  // memory pins
  input wire logic       addr_data_oe,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  logic [2:0] stretch;
  logic [2:0] cn;
  logic       active;
  logic       cw;
  logic [5:0] mcnt;
  logic [5:0] scnt;
  logic [5:0] exp_t;
  logic [5:0] exp_w;
  wire        strb_idle = rd_n && wr_n;
  wire        mapped = (sfr_addr >= 8'h82 && sfr_addr <= 8'h86) || sfr_addr == 8'h8E;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // expected length and strobe width for the stretch taken at start
  assign exp_t = ({3'h0, cn} + 6'h02) << 2;
  assign exp_w = (cn == 3'h0) ? 6'h02 : {1'b0, cn, 2'b00};

  // shadow stretch; a start during a move is dropped, so only idle starts count
  always_ff @(posedge clk) begin
    if (srst) begin
      stretch <= 3'h1;
      active  <= 1'b0;
      cn      <= 3'h0;
      cw      <= 1'b0;
      mcnt    <= 6'h00;
      scnt    <= 6'h00;
    end else begin
      if (sfr_wr && sfr_addr == 8'h8E)
        stretch <= sfr_wdata[2:0];
      if (ext_data_move_start && (!active || ext_data_move_done)) begin
        active <= 1'b1;
        cn     <= stretch;
        cw     <= ext_data_move_write;
        mcnt   <= 6'h01;
      end else begin
        if (ext_data_move_done)
          active <= 1'b0;
        mcnt <= mcnt + 6'h01;
      end
      scnt <= strb_idle ? 6'h00 : scnt + 6'h01;
    end
  end

  property p_len;
    // done is sampled one edge after the move's last clock
    ext_data_move_done |-> active && mcnt == exp_t + 6'h01;
  endproperty
  a_len: assert property (p_len)
    else $error("move length wrong");
  property p_width;
    $rose(strb_idle) |-> scnt == exp_w;
  endproperty
  a_width: assert property (p_width)
    else $error("strobe width wrong");
  property p_strb_at;
    $fell(strb_idle) |-> active && mcnt == 6'h06;
  endproperty
  a_strb_at: assert property (p_strb_at)
    else $error("strobe starts at wrong cycle");
  property p_ale;
    $rose(ale) |-> active && mcnt == 6'h02 ##1 ale ##1 !ale;
  endproperty
  a_ale: assert property (p_ale)
    else $error("address latch pulse wrong");
  property p_dir;
    !strb_idle |-> rd_n != wr_n && wr_n == !cw && addr_data_oe == cw;
  endproperty
  a_dir: assert property (p_dir)
    else $error("strobe direction wrong");
  property p_quiet;
    !active |-> strb_idle && !ale;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus activity outside a move");
  property p_sel;
    sfr_addr == 8'h86 |=> sfr_hit && sfr_rdata[7:1] == 7'h00;
  endproperty
  a_sel: assert property (p_sel)
    else $error("select register upper bits set");
  property p_unmap;
    !mapped |=> !sfr_hit && sfr_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped address answered");
endmodule
`default_nettype wire

//--- dv/xdm_mem.sv
// xdm_mem: behavioural external memory on the multiplexed bus.
// assumes: one clock with the device; latch loads on each clock while ale is high.
`timescale 1ns/1ns
`default_nettype none
module xdm_mem (
  // clock
  input  wire logic        clk,
  // device pins
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  addr_data_out,
  input  wire logic        addr_data_oe,
  input  wire logic [7:0]  high_addr_port,
  // speed and observation
  input  wire logic [4:0]  access_clks,
  output logic      [7:0]  addr_data_in,
  output logic      [15:0] last_addr
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] prev;
  logic [4:0] low_cnt;
  wire        ready = !rd_n && low_cnt >= access_clks;

  // full address is high port plus latched low byte
  assign last_addr = {high_addr_port, lat};
  // undriven bus shows the inverse of its last level, never a stale match
  assign addr_data_in = addr_data_oe ? addr_data_out : ready ? mem[last_addr] : ~prev;

  // slow parts answer only after access_clks of strobe
  always @(posedge clk) begin
    prev <= addr_data_in;
    low_cnt <= rd_n ? 5'h00 : (low_cnt == 5'h1F ? low_cnt : low_cnt + 5'h01);
    if (ale)
      lat <= addr_data_out;
    if (!wr_n)
      mem[last_addr] <= addr_data_out;
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// tb: register, pointer and data move tests on xdm_top with a memory model.
// assumes: inputs change on the falling edge; checker bound below.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, srst, sfr_wr, sfr_inc, sfr_hit, data_pointer_load, data_pointer_inc;
  logic        ext_data_move_start, ext_data_move_write, ext_data_move_use_ri;
  logic        ext_data_move_busy, ext_data_move_done, addr_data_oe, ale, rd_n, wr_n;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ext_data_move_ri_addr, ext_data_move_page;
  logic [7:0]  ext_data_move_wdata, ext_data_move_rdata, addr_data_in, addr_data_out;
  logic [7:0]  high_addr_port;
  logic [15:0] data_pointer_value, data_pointer, last_addr;
  logic [4:0]  access_clks;
  int          n_fail, checked, cyc;

  xdm_top xdm_top_i (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_inc, .sfr_wdata, .sfr_rdata,
    .sfr_hit, .data_pointer_load, .data_pointer_value, .data_pointer_inc, .data_pointer,
    .ext_data_move_start, .ext_data_move_write, .ext_data_move_use_ri,
    .ext_data_move_ri_addr, .ext_data_move_page, .ext_data_move_wdata, .ext_data_move_busy,
    .ext_data_move_done, .ext_data_move_rdata, .addr_data_in, .addr_data_out,
    .addr_data_oe, .high_addr_port, .ale, .rd_n, .wr_n);
  xdm_mem xdm_mem_i (.clk, .ale, .rd_n, .wr_n, .addr_data_out, .addr_data_oe,
    .high_addr_port, .access_clks, .addr_data_in, .last_addr);

  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard; a full run needs about 500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end

  task automatic cmpv(input logic [15:0] g, e, input string m);
    checked++;
    if (g !== e)
      $display("FAIL %0t %s got %h want %h", $time, m, g, e);
    if (g !== e)
      n_fail++;
  endtask
  task automatic cmpn(input int g, e, input string m);
    checked++;
    if (g != e)
      $display("FAIL %0t %s got %0d want %0d", $time, m, g, e);
    if (g != e)
      n_fail++;
  endtask

  // register write or increment, one cycle pulse
  task automatic sfr(input logic [7:0] a, d, input logic w, i);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_inc = i;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_inc = 1'b0;
    @(negedge clk); // idle clock: the next call never flips a strobe in one step
  endtask
  // read data follows the address by one edge
  task automatic rd(input logic [7:0] a, e);
    sfr_addr = a;
    @(negedge clk);
    cmpv(sfr_rdata, e, "register read");
  endtask
  // pointer load or increment, output two edges later
  task automatic dp(input logic ld, inc, input logic [15:0] v, e);
    data_pointer_load = ld;
    data_pointer_inc = inc;
    data_pointer_value = v;
    @(negedge clk);
    data_pointer_load = 1'b0;
    data_pointer_inc = 1'b0;
    @(negedge clk);
    cmpv(data_pointer, e, "pointer value");
  endtask
  // one move; x adds a start pulse in mid-move that must be dropped
  task automatic mv(input logic w, ri, input logic [15:0] a, input logic [7:0] d, e,
                    input int n, input logic x);
    int k;
    ext_data_move_start = 1'b1;
    ext_data_move_write = w;
    ext_data_move_use_ri = ri;
    {ext_data_move_page, ext_data_move_ri_addr} = a;
    ext_data_move_wdata = d;
    @(negedge clk);
    for (k = 0; k < 60; k++) begin
      if (ext_data_move_done === 1'b1)
        break;
      if (k == 2)
        cmpv(ext_data_move_busy, 1'b1, "busy during move");
      ext_data_move_start = x && k == 3;
      @(negedge clk);
    end
    cmpn(k, (n + 2) * 4, "move length");
    cmpv(ext_data_move_busy, 1'b0, "busy after move");
    cmpv(last_addr, a, "address pins");
    if (!w)
      cmpv(ext_data_move_rdata, e, "read data");
  endtask

  initial begin
    {srst, sfr_wr, sfr_inc, sfr_addr, sfr_wdata} = {1'b1, 18'h0_0000};
    {data_pointer_load, data_pointer_inc, data_pointer_value} = 18'h0_0000;
    {ext_data_move_start, ext_data_move_write, ext_data_move_use_ri} = 3'h0;
    {ext_data_move_ri_addr, ext_data_move_page, ext_data_move_wdata} = 24'h00_0000;
    access_clks = 5'h00;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    rd(8'h8E, 8'h01);
    rd(8'h86, 8'h00);
    rd(8'h80, 8'h00);
    sfr(8'h8F, 8'hFF, 1'b1, 1'b0);
    rd(8'h8F, 8'h00);
    sfr(8'h86, 8'hFF, 1'b1, 1'b0);
    rd(8'h86, 8'h01);
    sfr(8'h86, 8'h00, 1'b0, 1'b1);
    rd(8'h86, 8'h00);
    $display("test registers done");
    dp(1'b1, 1'b0, 16'h1234, 16'h1234);
    rd(8'h82, 8'h34);
    rd(8'h83, 8'h12);
    sfr(8'h86, 8'h00, 1'b0, 1'b1);
    dp(1'b0, 1'b0, 16'h0000, 16'h0000);
    sfr(8'h84, 8'hFF, 1'b1, 1'b0);
    sfr(8'h85, 8'hAB, 1'b1, 1'b0);
    dp(1'b0, 1'b1, 16'h0000, 16'hAC00);
    rd(8'h84, 8'h00);
    rd(8'h85, 8'hAC);
    mv(1'b1, 1'b0, 16'hAC00, 8'h3C, 8'h00, 1, 1'b0);
    sfr(8'h86, 8'h00, 1'b0, 1'b1);
    dp(1'b0, 1'b0, 16'h0000, 16'h1234);
    $display("test pointers done");
    mv(1'b0, 1'b1, 16'hAC00, 8'h00, 8'h3C, 1, 1'b0);
    for (int n = 0; n < 8; n++) begin
      sfr(8'h8E, {5'h15, n[2:0]}, 1'b1, 1'b0);
      rd(8'h8E, {5'h15, n[2:0]});
      mv(1'b1, 1'b1, {5'h00, n[2:0], 8'hC0}, 8'hA0 | n[7:0], 8'h00, n, 1'b0);
      mv(1'b0, 1'b1, {5'h00, n[2:0], 8'hC0}, 8'h00, 8'hA0 | n[7:0], n, n == 2);
    end
    $display("test stretch done");
    access_clks = 5'h08;
    sfr(8'h8E, 8'h03, 1'b1, 1'b0);
    mv(1'b1, 1'b0, 16'h1234, 8'h5A, 8'h00, 3, 1'b0);
    mv(1'b0, 1'b0, 16'h1234, 8'h00, 8'h5A, 3, 1'b0);
    $display("test slow memory done");
    results();
  end
endmodule

bind xdm_top xdm_props xdm_props_i (.clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
  .sfr_hit, .ext_data_move_start, .ext_data_move_write, .ext_data_move_done,
  .addr_data_oe, .ale, .rd_n, .wr_n);
`default_nettype wire
